// File: core/rt_ctrl_map.svh
// Register offsets, field positions, reset values and timing counts
`ifndef RT_CTRL_MAP_SVH
`define RT_CTRL_MAP_SVH

// ****************************************************************
// Register offsets (subaddresses)
// ****************************************************************
`define CHROMA_GAIN_CONTROL_OFS     8'h0F
`define CHROMA_CONTROL_TWO_OFS      8'h10
`define MODE_DELAY_CONTROL_OFS      8'h11
`define REALTIME_OUTPUT_SELECT_OFS  8'h12

// ****************************************************************
// Reset values (none documented, cleared)
// ****************************************************************
`define CHROMA_GAIN_CONTROL_RST     8'h00
`define CHROMA_CONTROL_TWO_RST      8'h00
`define MODE_DELAY_CONTROL_RST      8'h00
`define REALTIME_OUTPUT_SELECT_RST  8'h00

// ****************************************************************
// Field positions
// ****************************************************************
`define AUTO_CHROMA_GAIN_OFF_BIT    7
`define CHROMA_GAIN_VALUE_MSB       6
`define CHROMA_GAIN_VALUE_LSB       0
`define BLUE_DIFF_OFFSET_MSB        7
`define BLUE_DIFF_OFFSET_LSB        6
`define RED_DIFF_OFFSET_MSB         5
`define RED_DIFF_OFFSET_LSB         4
`define CHROMA_BANDWIDTH_WIDE_BIT   3
`define BANDWIDTH_SPLIT_MSB         2
`define BANDWIDTH_SPLIT_LSB         0
`define CHROMA_FORCE_ENABLE_BIT     7
`define RT_OUT1_INVERT_BIT          6
`define HSYNC_FINE_DELAY_MSB        5
`define HSYNC_FINE_DELAY_LSB        4
`define RT_OUT0_INVERT_BIT          3
`define LUMA_DELAY_COMP_MSB         2
`define LUMA_DELAY_COMP_LSB         0
`define OUT_PIN0_SELECT_MSB         3
`define OUT_PIN0_SELECT_LSB         0

// ****************************************************************
// Timing counts in line-locked clock periods
// ****************************************************************
`define DELAY_STEP_CLOCKS           2
`define CHROMA_FIXED_DELAY          8
`define LUMA_PIPE_DEPTH             14
`define HSYNC_PIPE_DEPTH            6

`endif

// File: core/rt_ctrl_pkg.sv
// Types of the chroma, delay and real-time output control block
package rt_ctrl_pkg;

  typedef enum logic [3:0] {
    PIN0_HIGH_Z      = 4'h0,
    PIN0_CONST_LOW   = 4'h1,
    PIN0_CLOCK_REF   = 4'h2,
    PIN0_CLOCK_HALF  = 4'h3,
    PIN0_HORIZ_LOCK  = 4'h4,
    PIN0_FRAME_LOCK  = 4'h5,
    PIN0_DECODE_LOCK = 4'h6
  } out_pin0_select_type;

  typedef struct packed {
    logic [7:0]       gain_ctrl;
    logic [7:0]       chroma_two;
    logic [7:0]       mode_delay;
    logic [7:0]       out_select;
    logic             clock_ref_pulse;
    logic             clock_ref_half_pulse;
    logic [13:0][7:0] luma_pipe;
    logic [7:0][7:0]  chroma_pipe;
    logic [5:0]       hsync_pipe;
    logic [7:0]       luma;
    logic [7:0]       chroma;
    logic             hsync;
    logic [6:0]       gain;
    logic             colour_on;
    logic             pin0;
    logic             pin0_oe;
    logic             pin1;
    logic [7:0]       rdata;
  } state_type;

endpackage

// File: core/chroma_delay_rt_output_control.sv
// Chroma gain, delay compensation and real-time output pin control registers
`timescale 1ns/100ps
// Summary of operation
// RULE1 - Gain mode bit: automatic or programmed gain
// RULE2 - Programmed gain code spans 0.5 to 7.5
// RULE3 - Two-bit fine offsets for both colour differences
// RULE4 - Bandwidth bit and three-bit chroma/luma split
// RULE5 - Force bit overrides the automatic colour killer
// RULE6 - Invert bit flips real-time output pin 1
// RULE7 - Invert bit flips real-time output pin 0
// RULE8 - Signed luma delay in two-clock steps
// RULE9 - Select code 0 floats, 1 drives low
// RULE10 - Select code 2 gives full-rate clock reference
// RULE11 - Select code 3 gives half-rate clock reference
// RULE12 - Select code 4 gives horizontal lock
// RULE13 - Select code 5 gives frame plus horizontal lock
// RULE14 - Select code 6 gives decoder lock indicator
// RULE15 - Decoder lock reads one when locked
// RULE16 - Horizontal sync fine delay, two-clock steps
// RULE17 - Select bit picks standard or fast lock
// RULE18 - Undefined select codes keep pin floating
`include "rt_ctrl_map.svh"

module chroma_delay_rt_output_control (
  // Clock and reset
  input  wire logic       core_clk_i,
  input  wire logic       rst_n_i,
  // Register port
  input  wire logic [7:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       reg_wr_i,
  output logic      [7:0] reg_rdata_o,
  // Decoder status
  input  wire logic [6:0] auto_gain_i,
  input  wire logic       colour_detect_i,
  input  wire logic       hlock_std_i,
  input  wire logic       hlock_fast_i,
  input  wire logic       frame_lock_i,
  input  wire logic       hlock_indicator_select_i,
  // Video datapath
  input  wire logic [7:0] luma_i,
  input  wire logic [7:0] chroma_i,
  input  wire logic       hsync_i,
  output logic      [7:0] luma_o,
  output logic      [7:0] chroma_o,
  output logic            hsync_o,
  // Chroma processing controls
  output logic      [6:0] chroma_gain_o,
  output logic            auto_chroma_gain_off_o,
  output logic      [1:0] blue_diff_fine_offset_o,
  output logic      [1:0] red_diff_fine_offset_o,
  output logic            chroma_bandwidth_wide_o,
  output logic      [2:0] bandwidth_split_o,
  output logic            colour_on_o,
  // Real-time pins
  input  wire logic       realtime_out_pin1_src_i,
  output logic            realtime_out_pin0_o,
  output logic            realtime_out_pin0_oe_o,
  output logic            realtime_out_pin1_o
);

  rt_ctrl_pkg::state_type state_reg;
  rt_ctrl_pkg::state_type state_next;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    logic [2:0] luma_steps;
    logic [1:0] hs_steps;
    logic       hlock_sel;
    logic       pin0_raw;
    logic       pin0_en;
    luma_steps = 3'h0;
    hs_steps   = 2'h0;
    hlock_sel  = 1'b0;
    pin0_raw   = 1'b0;
    pin0_en    = 1'b0;
    state_next = state_reg;

    if (reg_wr_i) begin
      unique case (reg_addr_i)
        `CHROMA_GAIN_CONTROL_OFS:    state_next.gain_ctrl  = reg_wdata_i;
        `CHROMA_CONTROL_TWO_OFS:     state_next.chroma_two = reg_wdata_i;
        `MODE_DELAY_CONTROL_OFS:     state_next.mode_delay = reg_wdata_i;
        `REALTIME_OUTPUT_SELECT_OFS: state_next.out_select = reg_wdata_i;
        default: begin
        end
      endcase
    end

    // Readback of stored values, unmapped reads as zero
    unique case (reg_addr_i)
      `CHROMA_GAIN_CONTROL_OFS:    state_next.rdata = state_reg.gain_ctrl;
      `CHROMA_CONTROL_TWO_OFS:     state_next.rdata = state_reg.chroma_two;
      `MODE_DELAY_CONTROL_OFS:     state_next.rdata = state_reg.mode_delay;
      `REALTIME_OUTPUT_SELECT_OFS: state_next.rdata = state_reg.out_select;
      default:                     state_next.rdata = 8'h00;
    endcase

    // Gain code: tracking loop or programmed value
    if (state_reg.gain_ctrl[`AUTO_CHROMA_GAIN_OFF_BIT]) begin // [RULE1]
      state_next.gain = state_reg.gain_ctrl[`CHROMA_GAIN_VALUE_MSB:`CHROMA_GAIN_VALUE_LSB]; // [RULE2]
    end else begin
      state_next.gain = auto_gain_i; // [RULE1]
    end

    state_next.colour_on = state_reg.mode_delay[`CHROMA_FORCE_ENABLE_BIT] | colour_detect_i; // [RULE5]

    // Chroma fixed delay is the centre of the luma range
    state_next.chroma_pipe[0] = chroma_i;
    state_next.luma_pipe[0]   = luma_i;
    for (int i = 1; i < `CHROMA_FIXED_DELAY; i++) begin
      state_next.chroma_pipe[i] = state_reg.chroma_pipe[i-1];
    end
    for (int i = 1; i < `LUMA_PIPE_DEPTH; i++) begin
      state_next.luma_pipe[i] = state_reg.luma_pipe[i-1];
    end
    state_next.chroma = state_reg.chroma_pipe[`CHROMA_FIXED_DELAY-1];

    // Signed code plus four gives the tap in steps
    luma_steps = {~state_reg.mode_delay[`LUMA_DELAY_COMP_MSB],
                  state_reg.mode_delay[`LUMA_DELAY_COMP_MSB-1:`LUMA_DELAY_COMP_LSB]}; // [RULE8]
    if (luma_steps == 3'h0) begin
      state_next.luma = luma_i;
    end else begin
      state_next.luma = state_reg.luma_pipe[`DELAY_STEP_CLOCKS*luma_steps-1]; // [RULE8]
    end

    state_next.hsync_pipe = {state_reg.hsync_pipe[`HSYNC_PIPE_DEPTH-2:0], hsync_i};
    hs_steps = state_reg.mode_delay[`HSYNC_FINE_DELAY_MSB:`HSYNC_FINE_DELAY_LSB]; // [RULE16]
    if (hs_steps == 2'h0) begin
      state_next.hsync = hsync_i;
    end else begin
      state_next.hsync = state_reg.hsync_pipe[`DELAY_STEP_CLOCKS*hs_steps-1]; // [RULE16]
    end

    // Reference pulses derived from the line-locked clock
    state_next.clock_ref_pulse = ~state_reg.clock_ref_pulse; // [RULE10]
    if (state_reg.clock_ref_pulse) begin
      state_next.clock_ref_half_pulse = ~state_reg.clock_ref_half_pulse; // [RULE11]
    end

    hlock_sel = hlock_indicator_select_i ? hlock_fast_i : hlock_std_i; // [RULE17]

    unique case (state_reg.out_select[`OUT_PIN0_SELECT_MSB:`OUT_PIN0_SELECT_LSB])
      rt_ctrl_pkg::PIN0_HIGH_Z: begin
        pin0_en = 1'b0; // [RULE9]
      end
      rt_ctrl_pkg::PIN0_CONST_LOW: begin
        pin0_en  = 1'b1;
        pin0_raw = 1'b0; // [RULE9]
      end
      rt_ctrl_pkg::PIN0_CLOCK_REF: begin
        pin0_en  = 1'b1;
        pin0_raw = state_reg.clock_ref_pulse; // [RULE10]
      end
      rt_ctrl_pkg::PIN0_CLOCK_HALF: begin
        pin0_en  = 1'b1;
        pin0_raw = state_reg.clock_ref_half_pulse; // [RULE11]
      end
      rt_ctrl_pkg::PIN0_HORIZ_LOCK: begin
        pin0_en  = 1'b1;
        pin0_raw = hlock_sel; // [RULE12]
      end
      rt_ctrl_pkg::PIN0_FRAME_LOCK: begin
        pin0_en  = 1'b1;
        pin0_raw = hlock_sel & frame_lock_i; // [RULE13]
      end
      rt_ctrl_pkg::PIN0_DECODE_LOCK: begin
        pin0_en  = 1'b1;
        pin0_raw = hlock_sel & frame_lock_i & colour_detect_i; // [RULE14] [RULE15]
      end
      default: begin
        pin0_en = 1'b0; // [RULE18]
      end
    endcase
    state_next.pin0_oe = pin0_en;
    // Floating pin is held low internally to avoid toggling a dead driver
    state_next.pin0 = pin0_en & (pin0_raw ^ state_reg.mode_delay[`RT_OUT0_INVERT_BIT]); // [RULE7]
    state_next.pin1 = realtime_out_pin1_src_i ^ state_reg.mode_delay[`RT_OUT1_INVERT_BIT]; // [RULE6]
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      state_reg            <= '0;
      state_reg.gain_ctrl  <= `CHROMA_GAIN_CONTROL_RST;
      state_reg.chroma_two <= `CHROMA_CONTROL_TWO_RST;
      state_reg.mode_delay <= `MODE_DELAY_CONTROL_RST;
      state_reg.out_select <= `REALTIME_OUTPUT_SELECT_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign reg_rdata_o             = state_reg.rdata;
  assign luma_o                  = state_reg.luma;
  assign chroma_o                = state_reg.chroma;
  assign hsync_o                 = state_reg.hsync;
  assign chroma_gain_o           = state_reg.gain;
  assign auto_chroma_gain_off_o  = state_reg.gain_ctrl[`AUTO_CHROMA_GAIN_OFF_BIT]; // [RULE1]
  assign blue_diff_fine_offset_o =
    state_reg.chroma_two[`BLUE_DIFF_OFFSET_MSB:`BLUE_DIFF_OFFSET_LSB]; // [RULE3]
  assign red_diff_fine_offset_o  =
    state_reg.chroma_two[`RED_DIFF_OFFSET_MSB:`RED_DIFF_OFFSET_LSB]; // [RULE3]
  assign chroma_bandwidth_wide_o = state_reg.chroma_two[`CHROMA_BANDWIDTH_WIDE_BIT]; // [RULE4]
  assign bandwidth_split_o       =
    state_reg.chroma_two[`BANDWIDTH_SPLIT_MSB:`BANDWIDTH_SPLIT_LSB]; // [RULE4]
  assign colour_on_o             = state_reg.colour_on;
  assign realtime_out_pin0_o     = state_reg.pin0;
  assign realtime_out_pin0_oe_o  = state_reg.pin0_oe;
  assign realtime_out_pin1_o     = state_reg.pin1;

endmodule

// File: verification/rt_ctrl_monitor.sv
// Checker of the chroma and real-time output control block
`timescale 1ns/100ps
module rt_ctrl_monitor (
  input wire logic       core_clk_i,
  input wire logic       rst_n_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic       reg_wr_i,
  input wire logic [6:0] auto_gain_i,
  input wire logic       colour_detect_i,
  input wire logic       hlock_std_i,
  input wire logic       hlock_fast_i,
  input wire logic       frame_lock_i,
  input wire logic       hlock_indicator_select_i,
  input wire logic [6:0] chroma_gain_o,
  input wire logic       auto_chroma_gain_off_o,
  input wire logic       colour_on_o,
  input wire logic       realtime_out_pin1_src_i,
  input wire logic       realtime_out_pin0_o,
  input wire logic       realtime_out_pin0_oe_o,
  input wire logic       realtime_out_pin1_o
);
  logic [7:0] gc_reg, md_reg, os_reg;
  logic       live_reg, hl, want, p0_want, p1_want, col_want;
  logic [6:0] gain_want;
  logic       s_off, s_lvl, s2, s3;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  // Shadow copies, so outputs can be tied to what was written
  always_ff @(posedge core_clk_i) begin
    live_reg <= rst_n_i;
    if (!rst_n_i) begin
      gc_reg <= 8'h00;
      md_reg <= 8'h00;
      os_reg <= 8'h00;
    end else if (reg_wr_i) begin
      if (reg_addr_i == 8'h0F) gc_reg <= reg_wdata_i;
      if (reg_addr_i == 8'h11) md_reg <= reg_wdata_i;
      if (reg_addr_i == 8'h12) os_reg <= reg_wdata_i;
    end
  end
  always_comb begin
    hl = hlock_indicator_select_i ? hlock_fast_i : hlock_std_i;
    case (os_reg[3:0])
      4'h4: want = hl;
      4'h5: want = hl & frame_lock_i;
      4'h6: want = hl & frame_lock_i & colour_detect_i;
      default: want = 1'b0;
    endcase
    p0_want = want ^ md_reg[3];
    p1_want = realtime_out_pin1_src_i ^ md_reg[6];
    col_want = md_reg[7] | colour_detect_i;
    gain_want = gc_reg[7] ? gc_reg[6:0] : auto_gain_i;
    s_off = (os_reg[3:0] == 4'h0) || (os_reg[3:0] > 4'h6);
    s_lvl = (os_reg[3:0] == 4'h1) || (os_reg[3:0] inside {4'h4, 4'h5, 4'h6});
    s2 = os_reg[3:0] == 4'h2;
    s3 = os_reg[3:0] == 4'h3;
  end
  a_pin1_polarity: assert property (live_reg |-> realtime_out_pin1_o == $past(p1_want))
    else $error("pin 1 polarity wrong");
  a_pin0_float: assert property (live_reg && $past(s_off) |-> !realtime_out_pin0_oe_o)
    else $error("pin 0 driven while it should float");
  a_pin0_level: assert property (live_reg && $past(s_lvl) |-> realtime_out_pin0_oe_o &&
    realtime_out_pin0_o == $past(p0_want)) else $error("pin 0 level wrong");
  a_full_toggle: assert property ($past(s2) && $past(s2, 2) |->
    realtime_out_pin0_oe_o && realtime_out_pin0_o != $past(realtime_out_pin0_o))
    else $error("clock reference does not toggle");
  a_half_toggle: assert property ($past(s3) && $past(s3, 3) |->
    realtime_out_pin0_o != $past(realtime_out_pin0_o, 2)) else $error("half clock wrong");
  a_gain_path: assert property (live_reg |-> chroma_gain_o == $past(gain_want))
    else $error("applied gain wrong");
  a_colour_force: assert property (live_reg |-> colour_on_o == $past(col_want))
    else $error("colour on wrong");
  a_gain_mode_bit: assert property (auto_chroma_gain_off_o == gc_reg[7])
    else $error("gain mode bit wrong");
  cover property (s2 && realtime_out_pin0_oe_o);
  cover property (md_reg[7] && colour_on_o);
  cover property (gc_reg[7] && chroma_gain_o == 7'h7F);
  cover property (os_reg[3:0] == 4'h6 && hl && frame_lock_i && colour_detect_i);
endmodule
bind chroma_delay_rt_output_control rt_ctrl_monitor i_rt_ctrl_monitor (
  .core_clk_i, .rst_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .auto_gain_i,
  .colour_detect_i, .hlock_std_i, .hlock_fast_i, .frame_lock_i, .hlock_indicator_select_i,
  .chroma_gain_o, .auto_chroma_gain_off_o, .colour_on_o, .realtime_out_pin1_src_i,
  .realtime_out_pin0_o, .realtime_out_pin0_oe_o, .realtime_out_pin1_o);

// File: verification/rt_pin_capture_model.sv
// Capture-side model of real-time output pin 0 as seen on the board wire
`timescale 1ns/100ps
module rt_pin_capture_model (
  // Clock
  input  wire logic core_clk_i,
  // Pin as driven
  input  wire logic pin_i,
  input  wire logic pin_oe_i,
  // Resolved wire
  output logic      wire_o
);
  logic last_reg = 1'b0;
  // No pull resistor: a floating wire must not keep its last level
  always_ff @(posedge core_clk_i) last_reg <= wire_o;
  assign wire_o = pin_oe_i ? pin_i : ~last_reg;
endmodule

// File: verification/chroma_delay_rt_output_control_test.sv
// Self-checking bench of the chroma and real-time output control block
`timescale 1ns/100ps
module chroma_delay_rt_output_control_test;
  logic       core_clk_i = 1'b0, rst_n_i = 1'b0, reg_wr_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, reg_rdata_o;
  logic [6:0] auto_gain_i = 7'h00, chroma_gain_o;
  logic       colour_detect_i = 1'b0, hlock_std_i = 1'b0, hlock_fast_i = 1'b0;
  logic       frame_lock_i = 1'b0, hlock_indicator_select_i = 1'b0;
  logic       realtime_out_pin1_src_i = 1'b1, auto_chroma_gain_off_o, colour_on_o;
  logic [1:0] blue_diff_fine_offset_o, red_diff_fine_offset_o;
  logic [2:0] bandwidth_split_o;
  logic       chroma_bandwidth_wide_o, realtime_out_pin0_o, realtime_out_pin0_oe_o;
  logic       realtime_out_pin1_o, pin_wire, hsync_o;
  logic [7:0] video_cnt = 8'h00, luma_o, chroma_o;
  int         errors = 0, tests_run = 0, cycles = 0;
  always #20 core_clk_i = ~core_clk_i;
  // Running count as video, so every output sample tells its own age
  always @(posedge core_clk_i) video_cnt <= video_cnt + 8'h01;
  chroma_delay_rt_output_control i_chroma_delay_rt_output_control (
    .core_clk_i, .rst_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rdata_o, .auto_gain_i,
    .colour_detect_i, .hlock_std_i, .hlock_fast_i, .frame_lock_i, .hlock_indicator_select_i,
    .luma_i(video_cnt), .chroma_i(video_cnt), .hsync_i(video_cnt[3]), .luma_o, .chroma_o, .hsync_o,
    .chroma_gain_o, .auto_chroma_gain_off_o, .blue_diff_fine_offset_o, .red_diff_fine_offset_o,
    .chroma_bandwidth_wide_o, .bandwidth_split_o, .colour_on_o, .realtime_out_pin1_src_i,
    .realtime_out_pin0_o, .realtime_out_pin0_oe_o, .realtime_out_pin1_o);
  rt_pin_capture_model i_rt_pin_capture_model (.core_clk_i(core_clk_i),
    .pin_i(realtime_out_pin0_o), .pin_oe_i(realtime_out_pin0_oe_o), .wire_o(pin_wire));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge core_clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    @(posedge core_clk_i);
    #1 chk(reg_rdata_o, exp);
  endtask
  task automatic settle;
    repeat (2) @(posedge core_clk_i);
    #1;
  endtask
  task automatic t_regs;
    for (int i = 0; i < 4; i++) rd(8'h0F + 8'(i), 8'h00);
    wr(8'h10, 8'hD5);
    settle;
    chk({blue_diff_fine_offset_o, red_diff_fine_offset_o, chroma_bandwidth_wide_o,
      bandwidth_split_o}, 8'hD5);
    wr(8'h10, 8'h2A);
    settle;
    chk({blue_diff_fine_offset_o, red_diff_fine_offset_o, chroma_bandwidth_wide_o,
      bandwidth_split_o}, 8'h2A);
    rd(8'h10, 8'h2A);
    wr(8'h13, 8'hFF);
    rd(8'h13, 8'h00);
    rd(8'h0E, 8'h00);
  endtask
  task automatic t_gain;
    logic [7:0] g [4];
    g = '{8'h00, 8'h80, 8'hA4, 8'hFF};
    @(posedge core_clk_i);
    auto_gain_i <= 7'h33;
    for (int i = 0; i < 4; i++) begin
      wr(8'h0F, g[i]);
      settle;
      chk({auto_chroma_gain_off_o, chroma_gain_o}, {g[i][7], g[i][7] ? g[i][6:0] : 7'h33});
    end
  endtask
  task automatic t_colour;
    for (int i = 0; i < 4; i++) begin
      wr(8'h11, {i[1:0], 6'h00});
      settle;
      chk({6'h00, colour_on_o, realtime_out_pin1_o}, {6'h00, i[1], ~i[0]});
    end
  endtask
  task automatic t_delay;
    int         sc;
    logic [7:0] hs;
    for (int c = 0; c < 8; c++) begin
      wr(8'h11, {2'h0, c[1:0], 1'b0, c[2:0]});
      settle;
      sc = (c < 4) ? c : c - 8;
      hs = 8'(int'(video_cnt) - 1 - 2 * (c % 4));
      chk(8'(video_cnt - chroma_o), 8'h09);
      chk(8'(chroma_o - luma_o), 8'(2 * sc));
      chk({7'h00, hsync_o}, {7'h00, hs[3]});
    end
  endtask
  task automatic t_pin0;
    logic [4:0] lk [3];
    logic       hl, v, drv, p;
    // Middle set: fast lock chosen over a low standard lock, all locks present
    lk = '{5'b0_1_0_1_0, 5'b1_0_1_1_1, 5'b1_0_1_0_1};
    for (int k = 0; k < 3; k++) begin
      @(posedge core_clk_i);
      {hlock_indicator_select_i, hlock_std_i, hlock_fast_i, frame_lock_i, colour_detect_i} <= lk[k];
      wr(8'h11, {4'h0, k[0], 3'h0});
      for (int c = 0; c < 16; c++) begin
        wr(8'h12, {4'hF, c[3:0]});
        settle;
        drv = (c >= 1) && (c <= 6);
        chk({7'h00, realtime_out_pin0_oe_o}, {7'h00, drv});
        hl = lk[k][4] ? lk[k][2] : lk[k][3];
        v = (c == 4) ? hl : (c == 5) ? hl & lk[k][1] : (c == 6) ? hl & lk[k][1] & lk[k][0] : 1'b0;
        if (c == 2 || c == 3) begin
          p = pin_wire;
          repeat (c - 1) @(posedge core_clk_i);
          #1 chk({7'h00, pin_wire}, {7'h00, ~p});
        end else if (drv) begin
          chk({7'h00, pin_wire}, {7'h00, v ^ k[0]});
        end
      end
    end
    rd(8'h12, 8'hFF);
  endtask
  task automatic conclude;
    if (errors == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      conclude;
    end
  end
  initial begin
    repeat (5) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    t_regs;
    t_gain;
    t_colour;
    t_delay;
    t_pin0;
    conclude;
  end
endmodule
